// File: shared/camera_rx_regs_pkg.sv
/*
  Register map, field positions and reset values for the camera receiver
  control and status register bank.
  Assumes a 7-bit decoded word-aligned address and 32-bit data.
*/
`default_nettype none
package camera_rx_regs_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int LANE_W = 2;
  localparam int CNT_W  = 16;
  localparam int BYTE_W = 16;
  localparam int N_EV   = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_LANE_CFG = 7'h04;
  localparam logic [ADDR_W-1:0] OFS_CORE_ST  = 7'h10;
  localparam logic [ADDR_W-1:0] OFS_GIE      = 7'h20;
  localparam logic [ADDR_W-1:0] OFS_EVENT    = 7'h24;
  localparam logic [ADDR_W-1:0] OFS_EV_EN    = 7'h28;

  // Lane configuration fields
  localparam int LANE_ACT_LSB = 0;
  localparam int LANE_MAX_LSB = 3;
  // Lane count fixed at generation, coded 0 = one lane .. 3 = four lanes
  localparam logic [LANE_W-1:0] LANES_GEN = 2'h3;

  // Core status fields
  localparam int ST_BUSY     = 0;
  localparam int ST_LB_FULL  = 1;
  localparam int ST_SPF_NE   = 2;
  localparam int ST_SPF_FULL = 3;
  localparam int ST_CNT_LSB  = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // Master enable bit
  localparam int GIE_BIT = 0;

  // Event bit positions in the register and internal event index
  localparam int EV_FRAME_BIT = 31;
  localparam int EV_WC_BIT    = 22;
  localparam int EV_LANE_BIT  = 21;
  localparam int IDX_FRAME    = 0;
  localparam int IDX_WC       = 1;
  localparam int IDX_LANE     = 2;

  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0]        RESP_OKAY = 2'h0;
endpackage : camera_rx_regs_pkg
`default_nettype wire

// File: logic/axil_port.sv
/*
  AXI4-Lite slave front end: one write and one read at a time.
  Assumes masters hold valid until ready; strobes are not used.
*/
`timescale 1ns/1ps
`default_nettype none
module axil_port (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic        i_awvalid,
  input  wire logic [6:0]  i_awaddr,
  input  wire logic        i_wvalid,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_bready,
  input  wire logic        i_arvalid,
  input  wire logic [6:0]  i_araddr,
  input  wire logic        i_rready,
  input  wire logic [31:0] i_rd_word,
  output logic             o_awready,
  output logic             o_wready,
  output logic             o_bvalid,
  output logic [1:0]       o_bresp,
  output logic             o_arready,
  output logic             o_rvalid,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_wr_en,
  output logic [6:0]       o_wr_addr,
  output logic [31:0]      o_wr_data,
  output logic [6:0]       o_rd_addr
);
  typedef struct packed {
    logic        aw_rdy;
    logic        ar_rdy;
    logic        bvalid;
    logic        rvalid;
    logic        wr_en;
    logic [6:0]  wr_addr;
    logic [31:0] wr_data;
    logic [6:0]  rd_addr;
    logic [31:0] rdata;
  } port_st_t;

  port_st_t s_q;
  port_st_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.aw_rdy = 1'b0;
    s_d.ar_rdy = 1'b0;
    s_d.wr_en  = 1'b0;
    // Write: accept address and data together
    if (i_awvalid && i_wvalid && !s_q.aw_rdy && !s_q.bvalid) begin
      s_d.aw_rdy  = 1'b1;
      s_d.wr_en   = 1'b1;
      s_d.wr_addr = i_awaddr;
      s_d.wr_data = i_wdata;
    end
    if (s_q.aw_rdy) begin
      s_d.bvalid = 1'b1;
    end else if (i_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read: latch address, capture word one cycle later
    if (i_arvalid && !s_q.ar_rdy && !s_q.rvalid) begin
      s_d.ar_rdy  = 1'b1;
      s_d.rd_addr = i_araddr;
    end
    if (s_q.ar_rdy) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = i_rd_word;
    end else if (i_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_awready = s_q.aw_rdy;
  assign o_wready  = s_q.aw_rdy;
  assign o_bvalid  = s_q.bvalid;
  assign o_bresp   = camera_rx_regs_pkg::RESP_OKAY;
  assign o_arready = s_q.ar_rdy;
  assign o_rvalid  = s_q.rvalid;
  assign o_rdata   = s_q.rdata;
  assign o_rresp   = camera_rx_regs_pkg::RESP_OKAY;
  assign o_wr_en   = s_q.wr_en;
  assign o_wr_addr = s_q.wr_addr;
  assign o_wr_data = s_q.wr_data;
  assign o_rd_addr = s_q.rd_addr;
endmodule : axil_port
`default_nettype wire

// File: logic/event_bits.sv
/*
  Sticky event flags, write one to clear, set wins over clear.
  Assumes set inputs are synchronous pulses or levels.
*/
`timescale 1ns/1ps
`default_nettype none
module event_bits (
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  input  wire logic [2:0] i_set,
  input  wire logic       i_clr_en,
  input  wire logic [2:0] i_clr_mask,
  output logic      [2:0] o_bits
);
  typedef struct packed {
    logic [2:0] bits;
  } ev_st_t;

  ev_st_t     s_q;
  ev_st_t     s_d;
  logic [2:0] nxt;

  for (genvar g = 0; g < camera_rx_regs_pkg::N_EV; g++) begin : g_bit
    assign nxt[g] = i_set[g] |
                    (s_q.bits[g] & ~(i_clr_en & i_clr_mask[g]));
  end

  always_comb begin
    s_d      = s_q;
    s_d.bits = nxt;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_bits = s_q.bits;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_set_wins;
    i_set[0] && i_clr_en && i_clr_mask[0] |=> o_bits[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Clear beat a set event");

  property p_w1c;
    !i_set[1] && i_clr_en && i_clr_mask[1] |=> !o_bits[1];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("Write one did not clear event");

  property p_zero_keeps;
    o_bits[2] && !(i_clr_en && i_clr_mask[2]) |=> o_bits[2];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("Event lost without a clear");
endmodule : event_bits
`default_nettype wire

// File: logic/camera_rx_ctrl_status_regs.sv
/*
  Control and status register bank of a camera serial receiver:
  lane configuration, core status, master enable, event status.
  Assumes all core inputs are synchronous to i_clk_sys and that software
  keeps the active lane count within the maximum.
*/
// Contract
// - Bits 4:3 of lane config read the fixed generated lane count.
// - Bits 1:0 select active lanes, reset to the generated count.
// - Reading active lanes returns the lane count the core now uses.
// - Status bits 31:16 count every long packet written, reset zero.
// - Packet counter wraps silently with no overflow indication.
// - Status bit 3 shows short packet FIFO full in real time.
// - Status bit 2 shows short packet FIFO not empty in real time.
// - Status bit 1 shows line buffer full in real time.
// - Status bit 0 high while soft reset or disable is in progress.
// - Master enable bit 0 is read-write and resets to zero.
// - Master enable zero holds the interrupt output inactive.
// - Master enable one lets per-source enables choose interrupt events.
// - Event bit 31 sets when a frame end packet arrives.
// - Event bit 22 sets when header count exceeds bytes received.
// - On count corruption process only the bytes actually delivered.
// - Event bits are sticky; write one clears, zero leaves unchanged.
// - A set event in the clearing cycle wins over the clear.
// - Event bit 21 sets while active lanes exceed maximum lanes.
// - Cleared per-source enable blocks only the interrupt, not capture.
`timescale 1ns/1ps
`default_nettype none
module camera_rx_ctrl_status_regs (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic        i_awvalid,
  input  wire logic [6:0]  i_awaddr,
  input  wire logic        i_wvalid,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_bready,
  input  wire logic        i_arvalid,
  input  wire logic [6:0]  i_araddr,
  input  wire logic        i_rready,
  input  wire logic [1:0]  i_lanes_in_use,
  input  wire logic        i_long_pkt_wr,
  input  wire logic        i_spf_full,
  input  wire logic        i_spf_not_empty,
  input  wire logic        i_line_buf_full,
  input  wire logic        i_reset_busy,
  input  wire logic        i_frame_end,
  input  wire logic        i_pkt_end,
  input  wire logic [15:0] i_hdr_wc,
  input  wire logic [15:0] i_rx_bytes,
  output logic             o_awready,
  output logic             o_wready,
  output logic             o_bvalid,
  output logic [1:0]       o_bresp,
  output logic             o_arready,
  output logic             o_rvalid,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic [1:0]       o_active_lanes,
  output logic             o_irq,
  output logic             o_pkt_done,
  output logic [15:0]      o_pkt_bytes
);
  typedef struct packed {
    logic [1:0]  active;
    logic        gie;
    logic [2:0]  ev_en;
    logic [15:0] pkt_cnt;
    logic        irq;
    logic        pkt_done;
    logic [15:0] pkt_bytes;
  } regs_st_t;

  regs_st_t    s_q;
  regs_st_t    s_d;
  logic        wr_en;
  logic [6:0]  wr_addr;
  logic [31:0] wr_data;
  logic [6:0]  rd_addr;
  logic [31:0] rd_word;
  logic [2:0]  ev_set;
  logic [2:0]  ev_bits;
  logic        ev_clr;
  logic [2:0]  ev_clr_mask;
  logic        lane_bad;
  logic        wc_bad;

  axil_port u_port (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_awvalid (i_awvalid),
    .i_awaddr  (i_awaddr),
    .i_wvalid  (i_wvalid),
    .i_wdata   (i_wdata),
    .i_bready  (i_bready),
    .i_arvalid (i_arvalid),
    .i_araddr  (i_araddr),
    .i_rready  (i_rready),
    .i_rd_word (rd_word),
    .o_awready (o_awready),
    .o_wready  (o_wready),
    .o_bvalid  (o_bvalid),
    .o_bresp   (o_bresp),
    .o_arready (o_arready),
    .o_rvalid  (o_rvalid),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_rd_addr (rd_addr)
  );

  // Event sources
  assign lane_bad = s_q.active > camera_rx_regs_pkg::LANES_GEN;
  assign wc_bad   = i_pkt_end && (i_rx_bytes < i_hdr_wc);
  assign ev_set[camera_rx_regs_pkg::IDX_FRAME] = i_frame_end;
  assign ev_set[camera_rx_regs_pkg::IDX_WC]    = wc_bad;
  assign ev_set[camera_rx_regs_pkg::IDX_LANE]  = lane_bad;

  // Write one to clear path
  assign ev_clr = wr_en && (wr_addr == camera_rx_regs_pkg::OFS_EVENT);
  assign ev_clr_mask[camera_rx_regs_pkg::IDX_FRAME] =
    wr_data[camera_rx_regs_pkg::EV_FRAME_BIT];
  assign ev_clr_mask[camera_rx_regs_pkg::IDX_WC] =
    wr_data[camera_rx_regs_pkg::EV_WC_BIT];
  assign ev_clr_mask[camera_rx_regs_pkg::IDX_LANE] =
    wr_data[camera_rx_regs_pkg::EV_LANE_BIT];

  event_bits u_events (
    .i_clk_sys  (i_clk_sys),
    .i_arst_n   (i_arst_n),
    .i_set      (ev_set),
    .i_clr_en   (ev_clr),
    .i_clr_mask (ev_clr_mask),
    .o_bits     (ev_bits)
  );

  // Per-source event layout in a 32-bit word
  function automatic logic [31:0] ev_word(input logic [2:0] v);
    logic [31:0] w;
    w = camera_rx_regs_pkg::WORD_ZERO;
    w[camera_rx_regs_pkg::EV_FRAME_BIT] = v[camera_rx_regs_pkg::IDX_FRAME];
    w[camera_rx_regs_pkg::EV_WC_BIT]    = v[camera_rx_regs_pkg::IDX_WC];
    w[camera_rx_regs_pkg::EV_LANE_BIT]  = v[camera_rx_regs_pkg::IDX_LANE];
    return w;
  endfunction : ev_word

  // Read data select, unmapped reads give zero
  always_comb begin
    rd_word = camera_rx_regs_pkg::WORD_ZERO;
    unique case (rd_addr)
      camera_rx_regs_pkg::OFS_LANE_CFG: begin
        rd_word[camera_rx_regs_pkg::LANE_MAX_LSB +: 2] =
          camera_rx_regs_pkg::LANES_GEN;
        rd_word[camera_rx_regs_pkg::LANE_ACT_LSB +: 2] =
          i_lanes_in_use;
      end
      camera_rx_regs_pkg::OFS_CORE_ST: begin
        rd_word[camera_rx_regs_pkg::ST_CNT_LSB +: 16] = s_q.pkt_cnt;
        rd_word[camera_rx_regs_pkg::ST_SPF_FULL] = i_spf_full;
        rd_word[camera_rx_regs_pkg::ST_SPF_NE]   = i_spf_not_empty;
        rd_word[camera_rx_regs_pkg::ST_LB_FULL]  = i_line_buf_full;
        rd_word[camera_rx_regs_pkg::ST_BUSY]     = i_reset_busy;
      end
      camera_rx_regs_pkg::OFS_GIE: begin
        rd_word[camera_rx_regs_pkg::GIE_BIT] = s_q.gie;
      end
      camera_rx_regs_pkg::OFS_EVENT: begin
        rd_word = ev_word(ev_bits);
      end
      camera_rx_regs_pkg::OFS_EV_EN: begin
        rd_word = ev_word(s_q.ev_en);
      end
      default: begin
        rd_word = camera_rx_regs_pkg::WORD_ZERO;
      end
    endcase
  end

  // Register state update
  always_comb begin
    s_d          = s_q;
    s_d.pkt_done = i_pkt_end;
    if (i_pkt_end) begin
      s_d.pkt_bytes = i_rx_bytes;
    end
    if (i_long_pkt_wr) begin
      s_d.pkt_cnt = s_q.pkt_cnt + camera_rx_regs_pkg::CNT_ONE;
    end
    if (wr_en) begin
      unique case (wr_addr)
        camera_rx_regs_pkg::OFS_LANE_CFG: begin
          s_d.active =
            wr_data[camera_rx_regs_pkg::LANE_ACT_LSB +: 2];
        end
        camera_rx_regs_pkg::OFS_GIE: begin
          s_d.gie = wr_data[camera_rx_regs_pkg::GIE_BIT];
        end
        camera_rx_regs_pkg::OFS_EV_EN: begin
          s_d.ev_en[camera_rx_regs_pkg::IDX_FRAME] =
            wr_data[camera_rx_regs_pkg::EV_FRAME_BIT];
          s_d.ev_en[camera_rx_regs_pkg::IDX_WC] =
            wr_data[camera_rx_regs_pkg::EV_WC_BIT];
          s_d.ev_en[camera_rx_regs_pkg::IDX_LANE] =
            wr_data[camera_rx_regs_pkg::EV_LANE_BIT];
        end
        default: begin
          s_d.active = s_q.active;
        end
      endcase
    end
    s_d.irq = s_q.gie && (|(ev_bits & s_q.ev_en));
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q        <= '0;
      s_q.active <= camera_rx_regs_pkg::LANES_GEN;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_active_lanes = s_q.active;
  assign o_irq          = s_q.irq;
  assign o_pkt_done     = s_q.pkt_done;
  assign o_pkt_bytes    = s_q.pkt_bytes;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence s_rd_lane;
    o_arready && (rd_addr == camera_rx_regs_pkg::OFS_LANE_CFG) ##1 o_rvalid;
  endsequence

  sequence s_rd_status;
    o_arready && (rd_addr == camera_rx_regs_pkg::OFS_CORE_ST) ##1 o_rvalid;
  endsequence

  property p_max_lanes;
    s_rd_lane |-> o_rdata[4:3] == camera_rx_regs_pkg::LANES_GEN;
  endproperty
  a_max_lanes: assert property (p_max_lanes)
    else $error("Maximum lane field wrong");

  property p_lanes_in_use;
    s_rd_lane |-> o_rdata[1:0] == $past(i_lanes_in_use);
  endproperty
  a_lanes_in_use: assert property (p_lanes_in_use)
    else $error("Active lane read not the lanes in use");

  property p_reserved_zero;
    s_rd_lane |-> o_rdata[31:5] == 27'h000_0000 && !o_rdata[2];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved lane config bits not zero");

  property p_status_live;
    s_rd_status |-> o_rdata[3:0] == $past({i_spf_full, i_spf_not_empty,
                                           i_line_buf_full, i_reset_busy});
  endproperty
  a_status_live: assert property (p_status_live)
    else $error("Status flags not real time");

  property p_pkt_count;
    i_long_pkt_wr |=> s_q.pkt_cnt == $past(s_q.pkt_cnt) + 16'h0001;
  endproperty
  a_pkt_count: assert property (p_pkt_count)
    else $error("Long packet count missed");

  property p_irq_blocked;
    !s_q.gie |=> !o_irq;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked)
    else $error("Interrupt with master enable off");

  property p_irq_fires;
    s_q.gie && ev_bits[0] && s_q.ev_en[0] |=> o_irq;
  endproperty
  a_irq_fires: assert property (p_irq_fires)
    else $error("Enabled event gave no interrupt");

  property p_capture_masked;
    i_frame_end && (s_q.ev_en == 3'h0) && !wr_en |=>
      ev_bits[0] && !o_irq ##1 !o_irq;
  endproperty
  a_capture_masked: assert property (p_capture_masked)
    else $error("Masked event not captured or raised interrupt");

  property p_wc_event;
    wc_bad |=> ev_bits[camera_rx_regs_pkg::IDX_WC];
  endproperty
  a_wc_event: assert property (p_wc_event)
    else $error("Word count corruption not flagged");

  property p_wc_bytes;
    i_pkt_end |=> o_pkt_done && o_pkt_bytes == $past(i_rx_bytes);
  endproperty
  a_wc_bytes: assert property (p_wc_bytes)
    else $error("Packet length not the delivered bytes");

  property p_lane_event;
    lane_bad |=> ev_bits[camera_rx_regs_pkg::IDX_LANE];
  endproperty
  a_lane_event: assert property (p_lane_event)
    else $error("Lane misconfiguration not flagged");
endmodule : camera_rx_ctrl_status_regs
`default_nettype wire

// File: dv/testbench.sv
/*
  Self-checking bench for the camera receiver register bank: AXI4-Lite
  read and write tasks, then test sequences with expected values.
  Assumes the bank's handshake timing and event latencies as handed over.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_clk_sys;
  logic        i_arst_n;
  logic        i_awvalid;
  logic        i_wvalid;
  logic        i_bready;
  logic        i_arvalid;
  logic        i_rready;
  logic [6:0]  i_awaddr;
  logic [6:0]  i_araddr;
  logic [31:0] i_wdata;
  logic [3:0]  i_wstrb;
  logic [1:0]  i_lanes_in_use;
  logic        i_long_pkt_wr;
  logic        i_spf_full;
  logic        i_spf_not_empty;
  logic        i_line_buf_full;
  logic        i_reset_busy;
  logic        i_frame_end;
  logic        i_pkt_end;
  logic [15:0] i_hdr_wc;
  logic [15:0] i_rx_bytes;
  logic        o_awready;
  logic        o_wready;
  logic        o_bvalid;
  logic        o_arready;
  logic        o_rvalid;
  logic [1:0]  o_bresp;
  logic [1:0]  o_rresp;
  logic [1:0]  o_active_lanes;
  logic [31:0] o_rdata;
  logic        o_irq;
  logic        o_pkt_done;
  logic [15:0] o_pkt_bytes;
  int          bad_count;
  int          checked;

  camera_rx_ctrl_status_regs dut (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_awvalid(i_awvalid),
    .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .i_bready(i_bready), .i_arvalid(i_arvalid),
    .i_araddr(i_araddr), .i_rready(i_rready),
    .i_lanes_in_use(i_lanes_in_use), .i_long_pkt_wr(i_long_pkt_wr),
    .i_spf_full(i_spf_full), .i_spf_not_empty(i_spf_not_empty),
    .i_line_buf_full(i_line_buf_full), .i_reset_busy(i_reset_busy),
    .i_frame_end(i_frame_end), .i_pkt_end(i_pkt_end),
    .i_hdr_wc(i_hdr_wc), .i_rx_bytes(i_rx_bytes),
    .o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid),
    .o_bresp(o_bresp), .o_arready(o_arready), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_active_lanes(o_active_lanes), .o_irq(o_irq),
    .o_pkt_done(o_pkt_done), .o_pkt_bytes(o_pkt_bytes)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_word(input string name, input logic [31:0] exp,
                          input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : chk_word

  // Handshake signal chosen by index
  function automatic logic hs_sig(input int k);
    case (k)
      0: return o_awready;
      1: return o_bvalid;
      2: return o_arready;
      default: return o_rvalid;
    endcase
  endfunction : hs_sig

  task automatic wait_for(input int k);
    int n;
    n = 0;
    while (hs_sig(k) !== 1'b1) begin
      @(negedge i_clk_sys);
      n++;
      if (n > 20) begin
        $display("[ERR] handshake %0d expected 1 seen 0", k);
        bad_count++;
        print_verdict();
      end
    end
  endtask : wait_for

  // Hit pulses a frame end in the cycle the write is taken
  task automatic wr(input logic [6:0] a, input logic [31:0] d,
                    input bit hit = 1'b0);
    @(negedge i_clk_sys);
    i_awvalid = 1'b1;
    i_wvalid = 1'b1;
    i_awaddr = a;
    i_wdata = d;
    @(negedge i_clk_sys);
    wait_for(0);
    chk_word("wready", 32'h0000_0001, {31'h0000_0000, o_wready});
    if (hit) i_frame_end = 1'b1;
    @(negedge i_clk_sys);
    i_awvalid = 1'b0;
    i_wvalid = 1'b0;
    i_frame_end = 1'b0;
    wait_for(1);
    chk_word("bresp", 32'h0000_0000, {30'h0000_0000, o_bresp});
    @(negedge i_clk_sys);
  endtask : wr

  task automatic rchk(input logic [6:0] a, input logic [31:0] exp,
                      input string name);
    @(negedge i_clk_sys);
    i_arvalid = 1'b1;
    i_araddr = a;
    @(negedge i_clk_sys);
    wait_for(2);
    @(negedge i_clk_sys);
    i_arvalid = 1'b0;
    wait_for(3);
    chk_word(name, exp, o_rdata);
    chk_word("rresp", 32'h0000_0000, {30'h0000_0000, o_rresp});
    @(negedge i_clk_sys);
  endtask : rchk

  task automatic pkts(input int n);
    repeat (n) begin
      @(negedge i_clk_sys);
      i_long_pkt_wr = 1'b1;
    end
    @(negedge i_clk_sys);
    i_long_pkt_wr = 1'b0;
  endtask : pkts

  task automatic frame();
    @(negedge i_clk_sys);
    i_frame_end = 1'b1;
    @(negedge i_clk_sys);
    i_frame_end = 1'b0;
  endtask : frame

  task automatic pkt_end(input logic [15:0] hdr, input logic [15:0] rx);
    @(negedge i_clk_sys);
    i_pkt_end = 1'b1;
    i_hdr_wc = hdr;
    i_rx_bytes = rx;
    @(negedge i_clk_sys);
    i_pkt_end = 1'b0;
    chk_word("pkt_done", 32'h0000_0001, {31'h0000_0000, o_pkt_done});
    chk_word("pkt_bytes", {16'h0000, rx}, {16'h0000, o_pkt_bytes});
  endtask : pkt_end

  task automatic irq_is(input logic exp);
    repeat (2) @(negedge i_clk_sys);
    chk_word("irq", {31'h0000_0000, exp}, {31'h0000_0000, o_irq});
  endtask : irq_is

  function automatic logic [31:0] lane_exp(input logic [1:0] use_code);
    return {27'h000_0000, camera_rx_regs_pkg::LANES_GEN, 1'b0, use_code};
  endfunction : lane_exp

  initial begin
    bad_count = 0;
    checked = 0;
    {i_awvalid, i_wvalid, i_arvalid, i_long_pkt_wr, i_frame_end} = '0;
    {i_spf_full, i_spf_not_empty, i_line_buf_full, i_reset_busy} = '0;
    i_pkt_end = 1'b0;
    i_awaddr = 7'h00;
    i_araddr = 7'h00;
    i_wdata = 32'h0000_0000;
    i_wstrb = 4'hf;
    i_bready = 1'b1;
    i_rready = 1'b1;
    i_lanes_in_use = 2'h3;
    i_hdr_wc = 16'h0000;
    i_rx_bytes = 16'h0000;
    i_arst_n = 1'b0;
    repeat (8) @(negedge i_clk_sys);
    i_arst_n = 1'b1;

    chk_word("lanes", 32'h0000_0003, {30'h0000_0000, o_active_lanes});
    rchk(camera_rx_regs_pkg::OFS_LANE_CFG, lane_exp(2'h3), "lane");
    rchk(camera_rx_regs_pkg::OFS_CORE_ST, 32'h0000_0000, "status");
    rchk(camera_rx_regs_pkg::OFS_GIE, 32'h0000_0000, "gie");
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h0000_0000, "event");
    $display("test reset done");

    for (int k = 0; k < 4; k++) begin
      wr(camera_rx_regs_pkg::OFS_LANE_CFG, 32'hffff_ffe4 | k);
      i_lanes_in_use = 2'(3 - k);
      chk_word("lanes", 32'(k), {30'h0000_0000, o_active_lanes});
      rchk(camera_rx_regs_pkg::OFS_LANE_CFG, lane_exp(2'(3 - k)), "lane");
    end
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h0000_0000, "event");
    $display("test lanes done");

    for (int b = 0; b < 4; b++) begin
      {i_spf_full, i_spf_not_empty, i_line_buf_full, i_reset_busy} =
        4'(1 << b);
      rchk(camera_rx_regs_pkg::OFS_CORE_ST, 32'(1 << b), "status");
    end
    {i_spf_full, i_spf_not_empty, i_line_buf_full, i_reset_busy} = '0;
    pkts(5);
    rchk(camera_rx_regs_pkg::OFS_CORE_ST, 32'h0005_0000, "count");
    pkts(65531);
    rchk(camera_rx_regs_pkg::OFS_CORE_ST, 32'h0000_0000, "count");
    $display("test status done");

    wr(camera_rx_regs_pkg::OFS_GIE, 32'hffff_ffff);
    rchk(camera_rx_regs_pkg::OFS_GIE, 32'h0000_0001, "gie");
    wr(camera_rx_regs_pkg::OFS_GIE, 32'h0000_0000);
    rchk(camera_rx_regs_pkg::OFS_GIE, 32'h0000_0000, "gie");
    wr(7'h0c, 32'hffff_ffff);
    rchk(7'h0c, 32'h0000_0000, "unmapped");
    $display("test enable done");

    pkt_end(16'h0040, 16'h0040);
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h0000_0000, "event");
    pkt_end(16'h0041, 16'h0040);
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h0040_0000, "event");
    frame();
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h8040_0000, "event");
    wr(camera_rx_regs_pkg::OFS_EV_EN, 32'hffff_ffff);
    rchk(camera_rx_regs_pkg::OFS_EV_EN, 32'h8060_0000, "ev_en");
    irq_is(1'b0);
    wr(camera_rx_regs_pkg::OFS_GIE, 32'h0000_0001);
    irq_is(1'b1);
    wr(camera_rx_regs_pkg::OFS_EVENT, 32'h0000_0000);
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h8040_0000, "event");
    wr(camera_rx_regs_pkg::OFS_EVENT, 32'h8000_0000);
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h0040_0000, "event");
    wr(camera_rx_regs_pkg::OFS_EV_EN, 32'h8000_0000);
    irq_is(1'b0);
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h0040_0000, "event");
    frame();
    irq_is(1'b1);
    wr(camera_rx_regs_pkg::OFS_EVENT, 32'hffff_ffff, 1'b1);
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h8000_0000, "event");
    wr(camera_rx_regs_pkg::OFS_EVENT, 32'h8000_0000);
    irq_is(1'b0);
    rchk(camera_rx_regs_pkg::OFS_EVENT, 32'h0000_0000, "event");
    $display("test events done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
